// ===== rtl/mwd_pkg.sv
package mwd_pkg;
	// field widths
	localparam int NEXT_W   = 6;
	localparam int BR_W     = 4;
	localparam int SCTL_W   = 3;
	localparam int SSEC_W   = 2;
	localparam int ASRC_W   = 4;
	localparam int EMIT_W   = 4;
	localparam int HI_W     = 5;
	localparam int LO_W     = 8;

	// high branch field codes
	localparam logic [3:0] BH_ZERO  = 4'h0;
	localparam logic [3:0] BH_ONE   = 4'h1;
	localparam logic [3:0] BH_RBIT0 = 4'h2;
	localparam logic [3:0] BH_AUX67 = 4'h3;
	localparam logic [3:0] BH_STIN  = 4'h4;
	localparam logic [3:0] BH_OPIN  = 4'h5;
	localparam logic [3:0] BH_CARRY = 4'h6;
	localparam logic [3:0] BH_S0    = 4'h7;
	localparam logic [3:0] BH_G0    = 4'hb;

	// low branch field codes
	localparam logic [3:0] BL_ZERO  = 4'h0;
	localparam logic [3:0] BL_ONE   = 4'h1;
	localparam logic [3:0] BL_PAGE  = 4'h2;
	localparam logic [3:0] BL_ADIN  = 4'h3;
	localparam logic [3:0] BL_SVIN  = 4'h4;
	localparam logic [3:0] BL_DECV  = 4'h5;
	localparam logic [3:0] BL_CARRY = 4'h6;
	localparam logic [3:0] BL_ZBUS  = 4'h7;
	localparam logic [3:0] BL_G7    = 4'h8;
	localparam logic [3:0] BL_S3    = 4'h9;
	localparam logic [3:0] BL_G1    = 4'hc;
	localparam logic [3:0] BL_INTERRUPT_TEST  = 4'hf;

	// storage control codes
	localparam logic [2:0] SC_WRITE = 3'h0;
	localparam logic [2:0] SC_COMP  = 3'h1;
	localparam logic [2:0] SC_STORE = 3'h2;
	localparam logic [2:0] SC_RD_IA = 3'h3;
	localparam logic [2:0] SC_RD_AL = 3'h4;
	localparam logic [2:0] SC_RD_T  = 3'h5;
	localparam logic [2:0] SC_EMIT  = 3'h6;
	localparam logic [2:0] SC_DUMMY = 3'h7;

	// storage sections
	localparam logic [1:0] SS_MAIN  = 2'h0;
	localparam logic [1:0] SS_LOCAL = 2'h1;
	localparam logic [1:0] SS_MUX   = 2'h2;
	localparam logic [1:0] SS_OPDEP = 2'h3;

	// alternate section codes
	localparam logic [1:0] AS_NONE  = 2'h0;
	localparam logic [1:0] AS_SELDR = 2'h1;
	localparam logic [1:0] AS_EMITW = 2'h2;
	localparam logic [1:0] AS_BACKUP = 2'h3;

	// a-source codes
	localparam logic [3:0] AQ_TAGS  = 4'h0;
	localparam logic [3:0] AQ_STAT  = 4'h4;
	localparam logic [3:0] AQ_BUSIN = 4'h6;

	// reset values
	localparam logic [4:0] HI_RST = 5'h00;
	localparam logic [7:0] LO_RST = 8'h00;

	typedef enum logic [1:0] {
		MWD_SEC_MAIN,
		MWD_SEC_LOCAL,
		MWD_SEC_MUX
	} mwd_section_t;

	typedef enum logic [1:0] {
		MWD_CYC_WRITE,
		MWD_CYC_COMPUTE,
		MWD_CYC_STORE,
		MWD_CYC_READ
	} mwd_cycle_t;

	typedef struct packed {
		logic [5:0] next_addr_field;
		logic [3:0] branch_hi_field;
		logic [3:0] branch_lo_field;
		logic [2:0] storage_ctl_field;
		logic [1:0] storage_section_field;
		logic [3:0] a_source_field;
		logic       alt_a_flag;
		logic [3:0] emit_const_field;
	} mwd_word_t;

	typedef struct packed {
		logic status_in;
		logic operation_in;
		logic address_in;
		logic service_in;
	} mwd_tags_t;

	typedef struct packed {
		mwd_cycle_t   cycle;
		mwd_section_t section;
		logic         use_selector_data_reg;
		logic         addr_load;
		logic [7:0]   addr_hi;
		logic [7:0]   addr_lo;
		logic         read_start;
	} mwd_stor_t;
endpackage : mwd_pkg

// ===== rtl/mwd_cond_sel.sv
`timescale 1ns/100ps
// sixteen-way condition mux for one branch field
module mwd_cond_sel
	import mwd_pkg::*;
(
	input  wire logic [3:0]  code,
	input  wire logic [15:0] conds,
	output logic             bit_out
);
	// an unsatisfied test leaves the bit cleared
	assign bit_out = conds[code];
endmodule : mwd_cond_sel

// ===== rtl/mwd_decoder.sv
`timescale 1ns/100ps
// What this block does
// - next-address bits 0-5 load straight from the next-address field.
// - high code 2 copies storage data register bit 0 into bit 6.
// - high code 3 sets bit 6 when auxiliary address bits 6 and 7 are zero.
// - high code 6 sets bit 6 on arithmetic carry out of position 0.
// - high codes 7-e test an even status or opcode bit for bit 6.
// - low codes 8-e test an odd status or opcode bit for bit 7.
// - page-change low code loads a-source and alt flag high, sets bit 7 without a backup load.
// - decimal-validity low code sets bit 7 when both nibbles are decimal digits.
// - low code 6 sets bit 7 on arithmetic carry out of position 1.
// - low code 7 sets bit 7 when the result bus is all zero.
// - interrupt-test low code sets bit 7 when any interrupt is pending.
// - status-in, op-in test bit 6; address-in, service-in test bit 7.
// - storage codes 0,1,2 are write, compute and store.
// - read codes load storage address from instruction, alternate or temporary.
// - one storage code loads low storage address from the emit constant.
// - section codes 0,1,2 select main, local store, mux control-word area.
// - section code 3 depends on opcode; register-to-register picks local store.
// - alternate section 1 uses selector data register for storage data.
// - alternate section 2 without page change loads high microaddress from emit constant.
// - alternate section 3 loads low, and high without page change, from mux backup; alternate 0 does nothing.
// - a-source field picks what drives the a-bus into the a register.
// - opcode top bits 00 select local store, otherwise main storage.
// - alternate section decodes act only on write, compute or store codes.
// - an unsatisfied branch condition clears its next-address bit.
module mwd_decoder
	import mwd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        word_valid,
	input  mwd_word_t        word,
	input  wire logic [7:0]  stor_data_reg,
	input  wire logic [7:0]  selector_data_reg,
	input  wire logic [7:0]  aux_addr_reg,
	input  wire logic [7:0]  status_reg,
	input  wire logic [7:0]  opcode_reg,
	input  wire logic        carry_pos0,
	input  wire logic        carry_pos1,
	input  wire logic [7:0]  result_bus,
	input  wire logic        interrupt_pending,
	input  mwd_tags_t        io_tags_pin,
	input  wire logic [7:0]  mux_tags_in_source,
	input  wire logic [7:0]  mux_bus_in_source,
	input  wire logic [7:0]  inst_addr_hi,
	input  wire logic [7:0]  inst_addr_lo,
	input  wire logic [7:0]  alt_addr_hi,
	input  wire logic [7:0]  alt_addr_lo,
	input  wire logic [7:0]  temp_addr,
	input  wire logic [4:0]  mux_backup_hi,
	input  wire logic [7:0]  mux_backup_lo,
	input  wire logic [7:0]  datapath_src_a,
	output logic [4:0]       micro_addr_hi,
	output logic [7:0]       micro_addr_lo,
	output logic [12:0]      micro_addr,
	output mwd_stor_t        stor,
	output logic [7:0]       stor_data_out,
	output logic [7:0]       a_bus
);
	mwd_tags_t  tags_meta;
	mwd_tags_t  tags;
	logic [15:0] hi_conds;
	logic [15:0] lo_conds;
	logic        bit6;
	logic        bit7;
	logic        alt_active;
	logic        rr_format;
	logic [7:0]  next_a_bus;

	function automatic logic is_dec_digit(input logic [3:0] nib);
		is_dec_digit = (nib <= 4'h9);
	endfunction : is_dec_digit

	// tags arrive from the channel pins unsynchronised
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tags_meta <= '0;
			tags      <= '0;
		end else begin
			tags_meta <= io_tags_pin;
			tags      <= tags_meta;
		end
	end

	always_comb begin
		hi_conds           = '0;
		hi_conds[BH_ONE]   = 1'b1;
		hi_conds[BH_RBIT0] = stor_data_reg[7];
		hi_conds[BH_AUX67] = (aux_addr_reg[0] == 1'b0) && (aux_addr_reg[1] == 1'b0);
		hi_conds[BH_STIN]  = tags.status_in;
		hi_conds[BH_OPIN]  = tags.operation_in;
		hi_conds[BH_CARRY] = carry_pos0;
		// bit numbering is msb-first: position n is vector bit 7-n
		for (int i = 0; i < 4; i++) begin
			hi_conds[BH_S0 + i] = status_reg[7 - 2 * i];
			hi_conds[BH_G0 + i] = opcode_reg[7 - 2 * i];
		end
	end

	always_comb begin
		lo_conds           = '0;
		lo_conds[BL_ONE]   = 1'b1;
		lo_conds[BL_PAGE]  = 1'b1;
		lo_conds[BL_ADIN]  = tags.address_in;
		lo_conds[BL_SVIN]  = tags.service_in;
		lo_conds[BL_DECV]  = is_dec_digit(stor_data_reg[7:4]) &&
			is_dec_digit(stor_data_reg[3:0]);
		lo_conds[BL_CARRY] = carry_pos1;
		lo_conds[BL_ZBUS]  = (result_bus == 8'h00);
		lo_conds[BL_G7]    = opcode_reg[0];
		for (int i = 0; i < 3; i++) begin
			lo_conds[BL_S3 + i] = status_reg[4 - 2 * i];
			lo_conds[BL_G1 + i] = opcode_reg[6 - 2 * i];
		end
		lo_conds[BL_INTERRUPT_TEST]  = interrupt_pending;
	end

	mwd_cond_sel u_hi_sel (
		.code    (word.branch_hi_field),
		.conds   (hi_conds),
		.bit_out (bit6)
	);

	mwd_cond_sel u_lo_sel (
		.code    (word.branch_lo_field),
		.conds   (lo_conds),
		.bit_out (bit7)
	);

	assign alt_active = (word.storage_ctl_field <= SC_STORE);
	assign rr_format  = (opcode_reg[7:6] == 2'b00);

	// low address register: all eight bits in one edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			micro_addr_lo <= LO_RST;
		end else if (word_valid) begin
			if (alt_active && word.storage_section_field == AS_BACKUP) begin
				micro_addr_lo <= mux_backup_lo;
			end else begin
				micro_addr_lo <= {word.next_addr_field, bit6, bit7};
			end
		end
	end

	// high address register; page change has priority over alternates
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			micro_addr_hi <= HI_RST;
		end else if (word_valid) begin
			if (word.branch_lo_field == BL_PAGE) begin
				micro_addr_hi <= {word.alt_a_flag, word.a_source_field};
			end else if (alt_active && word.storage_section_field == AS_EMITW) begin
				micro_addr_hi <= {1'b0, word.emit_const_field};
			end else if (alt_active && word.storage_section_field == AS_BACKUP) begin
				micro_addr_hi <= mux_backup_hi;
			end
		end
	end

	assign micro_addr = {micro_addr_hi, micro_addr_lo};

	// storage cycle control
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stor <= '0;
		end else begin
			stor.read_start <= 1'b0;
			stor.addr_load  <= 1'b0;
			if (word_valid) begin
				unique case (word.storage_ctl_field)
					SC_WRITE: stor.cycle <= MWD_CYC_WRITE;
					SC_COMP:  stor.cycle <= MWD_CYC_COMPUTE;
					SC_STORE: stor.cycle <= MWD_CYC_STORE;
					SC_RD_IA: begin
						stor.cycle      <= MWD_CYC_READ;
						stor.addr_load  <= 1'b1;
						stor.addr_hi    <= inst_addr_hi;
						stor.addr_lo    <= inst_addr_lo;
						stor.read_start <= 1'b1;
					end
					SC_RD_AL: begin
						stor.cycle      <= MWD_CYC_READ;
						stor.addr_load  <= 1'b1;
						stor.addr_hi    <= alt_addr_hi;
						stor.addr_lo    <= alt_addr_lo;
						stor.read_start <= 1'b1;
					end
					SC_RD_T: begin
						stor.cycle      <= MWD_CYC_READ;
						stor.addr_load  <= 1'b1;
						stor.addr_lo    <= temp_addr;
						stor.read_start <= 1'b1;
					end
					SC_EMIT: begin
						stor.cycle      <= MWD_CYC_READ;
						stor.addr_load  <= 1'b1;
						stor.addr_lo    <= {4'h0, word.emit_const_field};
						stor.read_start <= 1'b1;
					end
					SC_DUMMY: stor.cycle <= MWD_CYC_READ;
				endcase
				// alternate section codes replace the section select on write, compute and store codes
				if (alt_active) begin
					stor.use_selector_data_reg <=
						(word.storage_section_field == AS_SELDR);
				end else begin
					stor.use_selector_data_reg <= 1'b0;
					unique case (word.storage_section_field)
						SS_MAIN:  stor.section <= MWD_SEC_MAIN;
						SS_LOCAL: stor.section <= MWD_SEC_LOCAL;
						SS_MUX:   stor.section <= MWD_SEC_MUX;
						SS_OPDEP: stor.section <= rr_format ? MWD_SEC_LOCAL
							: MWD_SEC_MAIN;
					endcase
				end
			end
		end
	end

	// storage data path decodes the selection itself, in the same edge as the select flag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stor_data_out <= 8'h00;
		end else if (word_valid) begin
			stor_data_out <= (alt_active && word.storage_section_field == AS_SELDR)
				? selector_data_reg : stor_data_reg;
		end
	end

	// a-bus source; dummy codes drive zero
	always_comb begin
		next_a_bus = 8'h00;
		if (!word.alt_a_flag) begin
			unique case (word.a_source_field)
				AQ_TAGS:  next_a_bus = mux_tags_in_source;
				AQ_STAT:  next_a_bus = status_reg;
				AQ_BUSIN: next_a_bus = mux_bus_in_source;
				4'h1, 4'h2, 4'h3: next_a_bus = 8'h00;
				default:  next_a_bus = datapath_src_a;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			a_bus <= 8'h00;
		end else if (word_valid) begin
			a_bus <= next_a_bus;
		end
	end
endmodule : mwd_decoder

// ===== tb/mwd_decoder_chk.sv
`timescale 1ns/100ps
module mwd_decoder_chk
	import mwd_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        word_valid,
	input mwd_word_t        word,
	input wire logic [7:0]  stor_data_reg,
	input wire logic [7:0]  result_bus,
	input wire logic        interrupt_pending,
	input wire logic [7:0]  inst_addr_hi,
	input wire logic [7:0]  inst_addr_lo,
	input wire logic [4:0]  mux_backup_hi,
	input wire logic [7:0]  mux_backup_lo,
	input wire logic [4:0]  micro_addr_hi,
	input wire logic [7:0]  micro_addr_lo,
	input wire logic [12:0] micro_addr,
	input mwd_stor_t        stor
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// backup load overrides the next-address field
	wire bk = word.storage_ctl_field <= SC_STORE && word.storage_section_field == AS_BACKUP;
	sequence take_plain;
		word_valid && !bk;
	endsequence
	sequence take_read;
		word_valid ##0 word.storage_ctl_field == SC_RD_IA;
	endsequence
	chk_next_field: assert property (take_plain |=>
		micro_addr_lo[7:2] == $past(word.next_addr_field)) else $error("next field lost");
	chk_hi_const: assert property (take_plain ##0 word.branch_hi_field <= BH_ONE |=>
		micro_addr_lo[1] == $past(word.branch_hi_field[0])) else $error("const bit6 wrong");
	chk_rbit_copy: assert property (take_plain ##0 word.branch_hi_field == BH_RBIT0 |=>
		micro_addr_lo[1] == $past(stor_data_reg[7])) else $error("data bit copy wrong");
	chk_zero_bus: assert property (take_plain ##0 word.branch_lo_field == BL_ZBUS |=>
		micro_addr_lo[0] == ($past(result_bus) == 8'h00)) else $error("zero test wrong");
	chk_interrupt_test_test: assert property (take_plain ##0 word.branch_lo_field == BL_INTERRUPT_TEST |=>
		micro_addr_lo[0] == $past(interrupt_pending)) else $error("interrupt test wrong");
	chk_page_load: assert property (take_plain ##0 word.branch_lo_field == BL_PAGE |=>
		micro_addr_hi == {$past(word.alt_a_flag), $past(word.a_source_field)}
		&& micro_addr_lo[0]) else $error("page change wrong");
	chk_addr_join: assert property (micro_addr == {micro_addr_hi, micro_addr_lo})
		else $error("address join wrong");
	// page change owns the high register even on a backup load
	chk_backup_load: assert property (word_valid && bk |=>
		micro_addr_lo == $past(mux_backup_lo) && ($past(word.branch_lo_field) == BL_PAGE
		|| micro_addr_hi == $past(mux_backup_hi))) else $error("backup load wrong");
	chk_emit_hi: assert property (word_valid && word.storage_ctl_field <= SC_STORE
		&& word.storage_section_field == AS_EMITW && word.branch_lo_field != BL_PAGE
		|=> micro_addr_hi == {1'b0, $past(word.emit_const_field)})
		else $error("emit high load wrong");
	chk_read_inst: assert property (take_read |=> stor.read_start
		&& stor.addr_hi == $past(inst_addr_hi) && stor.addr_lo == $past(inst_addr_lo))
		else $error("instruction read wrong");
	chk_no_start: assert property (!word_valid |=> !stor.read_start && !stor.addr_load)
		else $error("pulse without word");
	chk_write_norw: assert property (word_valid && word.storage_ctl_field <= SC_STORE
		|=> !stor.read_start) else $error("read on write code");
endmodule : mwd_decoder_chk

bind mwd_decoder mwd_decoder_chk u_mwd_decoder_chk (.*);

// ===== tb/mwd_dp_model.sv
`timescale 1ns/100ps
// datapath side; instruction address low byte steps after each read like a counter
module mwd_dp_model
	import mwd_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rstn,
	input  mwd_stor_t  stor,
	output logic [7:0] selector_data_reg,
	output logic [7:0] inst_addr_hi,
	output logic [7:0] inst_addr_lo,
	output logic [7:0] alt_addr_hi,
	output logic [7:0] alt_addr_lo,
	output logic [7:0] temp_addr,
	output logic [4:0] mux_backup_hi,
	output logic [7:0] mux_backup_lo,
	output logic [7:0] mux_tags_in_source,
	output logic [7:0] mux_bus_in_source,
	output logic [7:0] datapath_src_a
);
	assign selector_data_reg = 8'hc3;
	assign inst_addr_hi = 8'h12;
	assign alt_addr_hi = 8'h56;
	assign alt_addr_lo = 8'h78;
	assign temp_addr = 8'h9e;
	assign mux_backup_hi = 5'h1b;
	assign mux_backup_lo = 8'hd4;
	assign mux_tags_in_source = 8'h3c;
	assign mux_bus_in_source = 8'ha5;
	assign datapath_src_a = 8'h69;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			inst_addr_lo <= 8'h34;
		else if (stor.read_start)
			inst_addr_lo <= inst_addr_lo + 8'h01;
endmodule : mwd_dp_model

// ===== tb/tb_microword_field_decoder.sv
`timescale 1ns/100ps
module tb_microword_field_decoder;
	import mwd_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, word_valid = 1'b0, carry_pos0 = 1'b0, carry_pos1 = 1'b0;
	logic interrupt_pending = 1'b0;
	mwd_word_t word = '0;
	mwd_tags_t io_tags_pin = '0;
	logic [7:0] stor_data_reg = 8'h00, aux_addr_reg = 8'h00, status_reg = 8'h00;
	logic [7:0] opcode_reg = 8'h00, result_bus = 8'h00;
	logic [7:0] selector_data_reg, inst_addr_hi, inst_addr_lo, alt_addr_hi, alt_addr_lo;
	logic [7:0] temp_addr, mux_backup_lo, mux_tags_in_source, mux_bus_in_source;
	logic [7:0] datapath_src_a, micro_addr_lo, stor_data_out, a_bus, xh, xl;
	logic [4:0] mux_backup_hi, micro_addr_hi;
	logic [12:0] micro_addr;
	mwd_stor_t stor;
	int bad_count = 0, n_compared = 0, cyc = 0;
	mwd_decoder u_mwd_decoder (.*);
	mwd_dp_model u_mwd_dp_model (.*);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic issue(input mwd_word_t w);
		@(posedge clk);
		word <= w;
		word_valid <= 1'b1;
		@(posedge clk);
		word_valid <= 1'b0;
		#1;
	endtask : issue
	// all conditions true or all false, except low codes 8-e which take the opposite value; tags need two extra cycles
	task automatic set_env(input logic a);
		@(posedge clk);
		stor_data_reg <= a ? 8'h80 : 8'h7a;
		aux_addr_reg <= a ? 8'h00 : 8'h03;
		status_reg <= a ? 8'haa : 8'h55;
		opcode_reg <= a ? 8'haa : 8'h55;
		carry_pos0 <= a;
		carry_pos1 <= a;
		result_bus <= a ? 8'h00 : 8'h01;
		interrupt_pending <= a;
		io_tags_pin <= {4{a}};
		repeat (3) @(posedge clk);
	endtask : set_env
	task automatic t_branch;
		mwd_word_t w;
		for (int a = 0; a < 2; a++) begin
			set_env(a[0]);
			for (int c = 0; c < 16; c++) begin
				w = '0;
				w.storage_ctl_field = SC_COMP;
				w.next_addr_field = 6'(c + 5);
				w.branch_hi_field = 4'(c);
				w.branch_lo_field = 4'(c);
				issue(w);
				check(micro_addr_lo[1], c == 1 || (a == 1 && c != 0 && c != 15));
				check(micro_addr_lo[0], c inside {[8:14]} ? a == 0 : c == 1 || c == 2
					|| (a == 1 && c != 0));
				check(micro_addr_lo[7:2], 6'(c + 5));
			end
		end
		$display("branch test done");
	endtask : t_branch
	task automatic t_page;
		mwd_word_t w;
		w = '0;
		w.storage_ctl_field = SC_COMP;
		w.branch_lo_field = BL_PAGE;
		w.a_source_field = 4'h5;
		w.alt_a_flag = 1'b1;
		w.next_addr_field = 6'h2a;
		issue(w);
		check(micro_addr_hi, 5'h15);
		check(micro_addr, {5'h15, 6'h2a, 2'b01});
		check(a_bus, 8'h00);
		$display("page test done");
	endtask : t_page
	task automatic t_stor;
		mwd_word_t w;
		for (int c = 0; c < 8; c++) begin
			w = '0;
			w.storage_ctl_field = 3'(c);
			w.emit_const_field = 4'h9;
			xh = c == 4 ? alt_addr_hi : inst_addr_hi;
			xl = c == 3 ? inst_addr_lo : c == 4 ? alt_addr_lo : c == 5 ? temp_addr : 8'h09;
			issue(w);
			check(stor.cycle, c < 3 ? c : 3);
			check(stor.read_start, c > 2 && c < 7);
			check(stor.addr_load, c > 2 && c < 7);
			if (c == 3 || c == 4) check(stor.addr_hi, xh);
			if (c > 2 && c < 7) check(stor.addr_lo, xl);
		end
		for (int s = 0; s < 5; s++) begin
			w = '0;
			w.storage_ctl_field = SC_RD_IA;
			w.storage_section_field = 2'(s > 3 ? 3 : s);
			@(posedge clk);
			opcode_reg <= s == 3 ? 8'h3f : 8'h40;
			issue(w);
			check(stor.section, s == 1 || s == 3 ? MWD_SEC_LOCAL
				: s == 2 ? MWD_SEC_MUX : MWD_SEC_MAIN);
			if (s == 1) check(stor.use_selector_data_reg, 1'b0);
		end
		$display("storage test done");
	endtask : t_stor
	task automatic t_alt;
		mwd_word_t w;
		w = '0;
		w.storage_section_field = AS_EMITW;
		w.emit_const_field = 4'h6;
		issue(w);
		check(micro_addr_hi, 5'h06);
		w.storage_section_field = AS_BACKUP;
		issue(w);
		check(micro_addr, {mux_backup_hi, mux_backup_lo});
		w.storage_section_field = AS_NONE;
		issue(w);
		check(micro_addr_hi, mux_backup_hi);
		w.storage_section_field = AS_SELDR;
		issue(w);
		check(stor.use_selector_data_reg, 1'b1);
		check(stor_data_out, selector_data_reg);
		$display("alternate test done");
	endtask : t_alt
	task automatic t_asrc;
		mwd_word_t w;
		for (int i = 0; i < 5; i++) begin
			w = '0;
			w.storage_ctl_field = SC_COMP;
			w.a_source_field = i == 0 ? AQ_TAGS : i == 1 ? AQ_STAT : i == 2 ? AQ_BUSIN
				: i == 3 ? 4'h2 : 4'h9;
			issue(w);
			check(a_bus, i == 0 ? mux_tags_in_source : i == 1 ? status_reg
				: i == 2 ? mux_bus_in_source : i == 3 ? 8'h00 : datapath_src_a);
		end
		$display("a-source test done");
	endtask : t_asrc
	// mid-run reset: micro address, storage cycle and low address, data out and a-bus back to zero, then decoding resumes
	task automatic t_reset;
		mwd_word_t w;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(micro_addr, 13'h0000);
		check(stor.cycle, MWD_CYC_WRITE);
		check(stor.addr_lo, 8'h00);
		check(stor_data_out, 8'h00);
		check(a_bus, 8'h00);
		@(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		w = '0;
		w.storage_ctl_field = SC_COMP;
		w.next_addr_field = 6'h11;
		issue(w);
		check(micro_addr_lo, 8'h44);
		$display("reset test done");
	endtask : t_reset
	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_branch();
		t_page();
		t_stor();
		t_alt();
		t_asrc();
		t_reset();
		conclude();
	end
endmodule : tb_microword_field_decoder
